// File: design/wod_cfg.svh
// constants of the wide opcode decoder: match entries, fields, scope
// assumes inclusion by the decoder package and design files only
`ifndef WOD_CFG_SVH
`define WOD_CFG_SVH

// ============================================================
// match entries: {care mask, required value}
`define WOD_NUM_ENTRIES 49
`define WOD_E_ALIGN1 64'hffff_f1c0_c60d_0000
`define WOD_E_ALIGN2 64'hffff_f1c0_c60d_4000
`define WOD_E_ALIGN3 64'hffff_f1c0_c60d_8000
`define WOD_E_HALF_ASR 64'hffff_c180_c680_0180
`define WOD_E_HALF_SATL 64'hffff_c180_c680_4000
`define WOD_E_HALF_LSL 64'hffff_c180_c680_8000
`define WOD_E_HALF_LSR 64'hffff_c180_c680_8180
`define WOD_E_VEC_ASR 64'hffff_f100_c681_0100
`define WOD_E_VEC_SATL 64'hffff_f100_c681_4000
`define WOD_E_VEC_LSL 64'hffff_f180_c681_8000
`define WOD_E_VEC_LSR 64'hffff_f180_c681_8180
`define WOD_E_WORD_ASR 64'hffff_f100_c682_0100
`define WOD_E_WORD_SATL 64'hffff_f100_c682_4000
`define WOD_E_WORD_LSL 64'hffff_f100_c682_8000
`define WOD_E_WORD_LSR 64'hffff_f100_c682_8100
`define WOD_E_WORD_ROTATE 64'hffff_f000_c682_c000
`define WOD_E_ACC0_ASR 64'hffff_ff07_c683_0100
`define WOD_E_ACC1_ASR 64'hffff_ff07_c683_1100
`define WOD_E_ACC0_LSL 64'hffff_ff07_c683_4000
`define WOD_E_ACC0_LSR 64'hffff_ff07_c683_4100
`define WOD_E_ACC1_LSL 64'hffff_ff07_c683_5000
`define WOD_E_ACC1_LSR 64'hffff_ff07_c683_5100
`define WOD_E_ACC0_ROTATE 64'hffff_fe07_c683_8000
`define WOD_E_ACC1_ROTATE 64'hffff_fe07_c683_9000
`define WOD_E_MULTI_NOOP 64'hffff_ffff_c803_1800
`define WOD_E_LOOP0 64'hfff0_fc00_e080_0000
`define WOD_E_LOOP1 64'hfff0_fc00_e090_0000
`define WOD_E_LOOP0_P 64'hfff0_0c00_e0a0_0000
`define WOD_E_LOOP1_P 64'hfff0_0c00_e0b0_0000
`define WOD_E_LOOP0_PH 64'hfff0_0c00_e0e0_0000
`define WOD_E_LOOP1_PH 64'hfff0_0c00_e0f0_0000
`define WOD_E_LDI_LO 64'hffe0_0000_e100_0000
`define WOD_E_LDI_X 64'hffe0_0000_e120_0000
`define WOD_E_LDI_HI 64'hffe0_0000_e140_0000
`define WOD_E_LDI_Z 64'hffe0_0000_e180_0000
`define WOD_E_JUMP_L 64'hff00_0000_e200_0000
`define WOD_E_CALL 64'hff00_0000_e300_0000
`define WOD_E_LD_D 64'hffc0_0000_e400_0000
`define WOD_E_LD_HZ 64'hffc0_0000_e440_0000
`define WOD_E_LD_BZ 64'hffc0_0000_e480_0000
`define WOD_E_LD_P 64'hffc0_0000_e500_0000
`define WOD_E_LD_HX 64'hffc0_0000_e540_0000
`define WOD_E_LD_BX 64'hffc0_0000_e580_0000
`define WOD_E_ST_D 64'hffc0_0000_e600_0000
`define WOD_E_ST_H 64'hffc0_0000_e640_0000
`define WOD_E_ST_B 64'hffc0_0000_e680_0000
`define WOD_E_ST_P 64'hffc0_0000_e700_0000
`define WOD_E_LINK 64'hffff_0000_e800_0000
`define WOD_E_FRAME_POP 64'hffff_ffff_e801_0000

// ============================================================
// scope of this decoder and field positions
`define WOD_SCOPE_ALIGN 16'hc60d
`define WOD_SCOPE_SHIFT_LO 16'hc680
`define WOD_SCOPE_SHIFT_HI 16'hc683
`define WOD_SCOPE_NOOP 16'hc803
`define WOD_SCOPE_MEM_LO 8'he0
`define WOD_SCOPE_MEM_HI 8'he8
`define WOD_SUB_BIT 15
`define WOD_SRC_HALF_BIT 12
`define WOD_DST_HALF_BIT 13

`endif

// File: design/wod_pkg.sv
// types of the wide opcode decoder
// assumes wod_cfg.svh for the entry count
`include "wod_cfg.svh"

package wod_pkg;
  // ============================================================
  // operation classes, in the order of the match table
  typedef enum logic [5:0] {
    op_align1, op_align2, op_align3,
    op_half_asr, op_half_satl, op_half_lsl, op_half_lsr,
    op_vec_asr, op_vec_satl, op_vec_lsl, op_vec_lsr,
    op_word_asr, op_word_satl, op_word_lsl, op_word_lsr, op_word_rotate,
    op_acc0_asr, op_acc1_asr, op_acc0_lsl, op_acc0_lsr,
    op_acc1_lsl, op_acc1_lsr, op_acc0_rotate, op_acc1_rotate,
    op_multi_noop,
    op_loop0, op_loop1, op_loop0_p, op_loop1_p, op_loop0_ph, op_loop1_ph,
    op_ldi_lo, op_ldi_x, op_ldi_hi, op_ldi_z,
    op_jump_l, op_call,
    op_ld_d, op_ld_hz, op_ld_bz, op_ld_p, op_ld_hx, op_ld_bx,
    op_st_d, op_st_h, op_st_b, op_st_p,
    op_link, op_frame_pop,
    op_none
  } wod_op_t;

  typedef logic [63:0] wod_entry_t;
endpackage : wod_pkg

// File: design/wod_match_if.sv
// carries a fetched word to the matcher and its hit vector back
// assumes one entry per operation class
`timescale 1ns/1ps
`include "wod_cfg.svh"

interface wod_match_if #(parameter int N = `WOD_NUM_ENTRIES);
  logic [31:0] word;
  logic [N-1:0] hit;
  modport matcher (input word, output hit);
  modport user (output word, input hit);
endinterface : wod_match_if

// File: design/wod_range_match.sv
// bank of mask and value comparators, one per match entry
// assumes a purely combinational path; the caller registers results
`timescale 1ns/1ps
`include "wod_cfg.svh"

module wod_range_match
  import wod_pkg::*;
#(
  parameter int N = `WOD_NUM_ENTRIES,
  parameter wod_entry_t TABLE [N] = '{default: 64'h0}
) (
  wod_match_if.matcher mif
);
  // ============================================================
  // comparators
  for (genvar i = 0; i < N; i++) begin : g_cmp
    assign mif.hit[i] = (mif.word & TABLE[i][63:32]) == TABLE[i][31:0];
  end
endmodule : wod_range_match

// File: design/wod_decoder.sv
// decoder for the upper part of the 32-bit instruction map
// assumes fetch and execute share clk_in; one word per handshake
`timescale 1ns/1ps
`include "wod_cfg.svh"

// Summary of operation
// RULE1: align ranges merge registers, one/two/three bytes
// RULE2: half arithmetic right shift, four-bit immediate
// RULE3: half saturating left shift, four-bit immediate
// RULE4: half logical shifts; offset 0x180 shifts right
// RULE5: paired-half arithmetic right, saturating left shifts
// RULE6: paired-half logical left and right shifts
// RULE7: word arithmetic right and saturating left shifts
// RULE8: word logical left and right shifts
// RULE9: word rotate by signed six-bit immediate
// RULE10: accumulator arithmetic right shift, both accumulators
// RULE11: accumulator logical left and right shifts
// RULE12: accumulator rotate by six-bit immediate
// RULE13: single word decodes as multi-issue no-op
// RULE14: loop setup for counter zero and one
// RULE15: loop setup loading count from pointer
// RULE16: four immediate load forms, half or whole
// RULE17: long jump and call, 25-bit even offset
// RULE18: word loads; upper sub-range subtracts offset
// RULE19: zero-extending half and byte loads
// RULE20: sign-extending half and byte loads
// RULE21: word, half, byte and pointer stores
// RULE22: frame link with size, and frame pop
// RULE23: unmatched word in scope flagged illegal
module wod_decoder
  import wod_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic fetch_valid_in,
  input wire logic [31:0] fetch_word_in,
  output logic fetch_ready_out,
  input wire logic exec_ready_in,
  output logic dec_valid_out,
  output logic dec_claim_out,
  output logic dec_illegal_out,
  output wod_op_t dec_op_out,
  output logic [31:0] dec_word_out,
  output logic [31:0] dec_imm_out,
  output logic [31:0] dec_aux_out,
  output logic dec_sub_out,
  output logic dec_src_high_out,
  output logic dec_dst_high_out,
  output logic dec_sat_out,
  output logic dec_unit_one_out,
  output logic dec_count_halved_out
);
  // ============================================================
  // match table, index equals operation class
  localparam int N = `WOD_NUM_ENTRIES;
  localparam wod_entry_t TABLE [N] = '{
    `WOD_E_ALIGN1, `WOD_E_ALIGN2, `WOD_E_ALIGN3, // RULE1
    `WOD_E_HALF_ASR, // RULE2
    `WOD_E_HALF_SATL, // RULE3
    `WOD_E_HALF_LSL, `WOD_E_HALF_LSR, // RULE4
    `WOD_E_VEC_ASR, `WOD_E_VEC_SATL, // RULE5
    `WOD_E_VEC_LSL, `WOD_E_VEC_LSR, // RULE6
    `WOD_E_WORD_ASR, `WOD_E_WORD_SATL, // RULE7
    `WOD_E_WORD_LSL, `WOD_E_WORD_LSR, // RULE8
    `WOD_E_WORD_ROTATE, // RULE9
    `WOD_E_ACC0_ASR, `WOD_E_ACC1_ASR, // RULE10
    `WOD_E_ACC0_LSL, `WOD_E_ACC0_LSR, // RULE11
    `WOD_E_ACC1_LSL, `WOD_E_ACC1_LSR, // RULE11
    `WOD_E_ACC0_ROTATE, `WOD_E_ACC1_ROTATE, // RULE12
    `WOD_E_MULTI_NOOP, // RULE13
    `WOD_E_LOOP0, `WOD_E_LOOP1, // RULE14
    `WOD_E_LOOP0_P, `WOD_E_LOOP1_P, // RULE15
    `WOD_E_LOOP0_PH, `WOD_E_LOOP1_PH, // RULE15
    `WOD_E_LDI_LO, `WOD_E_LDI_X, // RULE16
    `WOD_E_LDI_HI, `WOD_E_LDI_Z, // RULE16
    `WOD_E_JUMP_L, `WOD_E_CALL, // RULE17
    `WOD_E_LD_D, // RULE18
    `WOD_E_LD_HZ, `WOD_E_LD_BZ, // RULE19
    `WOD_E_LD_P, // RULE18
    `WOD_E_LD_HX, `WOD_E_LD_BX, // RULE20
    `WOD_E_ST_D, `WOD_E_ST_H, // RULE21
    `WOD_E_ST_B, `WOD_E_ST_P, // RULE21
    `WOD_E_LINK, `WOD_E_FRAME_POP // RULE22
  };

  // ============================================================
  // comparator bank
  wod_match_if #(.N(N)) mif ();
  assign mif.word = fetch_word_in;

  wod_range_match #(.N(N), .TABLE(TABLE)) u_match (
    .mif(mif)
  );

  // ============================================================
  // classification of the fetched word
  logic fire;
  logic in_scope;
  wod_op_t op_next;
  logic [31:0] imm_next;
  logic [31:0] aux_next;
  logic sub_next;
  logic half_op;
  logic sat_next;
  logic unit_one_next;
  logic halved_next;

  assign fetch_ready_out = !dec_valid_out || exec_ready_in;
  assign fire = fetch_valid_in && fetch_ready_out;

  // words outside this scope belong to other decoders
  assign in_scope = (fetch_word_in[31:16] == `WOD_SCOPE_ALIGN) ||
                    (fetch_word_in[31:16] >= `WOD_SCOPE_SHIFT_LO &&
                     fetch_word_in[31:16] <= `WOD_SCOPE_SHIFT_HI) ||
                    (fetch_word_in[31:16] == `WOD_SCOPE_NOOP) ||
                    (fetch_word_in[31:24] >= `WOD_SCOPE_MEM_LO &&
                     fetch_word_in[31:24] <= `WOD_SCOPE_MEM_HI);

  // entries never overlap, so the lowest hit is the only hit
  always_comb begin
    op_next = op_none;
    for (int i = N - 1; i >= 0; i--) begin
      if (mif.hit[i]) begin
        op_next = wod_op_t'(i[5:0]);
      end
    end
  end

  // immediate field, extended and scaled for the execution units
  always_comb begin
    logic [31:0] w;
    w = fetch_word_in;
    imm_next = 32'h0;
    aux_next = 32'h0;
    case (op_next)
      op_align1: imm_next = 32'h1; // RULE1
      op_align2: imm_next = 32'h2; // RULE1
      op_align3: imm_next = 32'h3; // RULE1
      op_half_asr, op_half_satl, op_half_lsl, op_half_lsr,
      op_vec_lsl, op_vec_lsr: begin
        imm_next = {28'h0, w[6:3]}; // RULE2 RULE3 RULE4 RULE6
      end
      op_vec_asr, op_vec_satl, op_word_asr, op_word_satl,
      op_word_lsl, op_word_lsr, op_acc0_asr, op_acc1_asr,
      op_acc0_lsl, op_acc0_lsr, op_acc1_lsl, op_acc1_lsr: begin
        imm_next = {27'h0, w[7:3]}; // RULE5 RULE7 RULE8 RULE10 RULE11
      end
      op_word_rotate, op_acc0_rotate, op_acc1_rotate: begin
        imm_next = {{26{w[8]}}, w[8:3]}; // RULE9 RULE12
      end
      op_loop0, op_loop1, op_loop0_p, op_loop1_p,
      op_loop0_ph, op_loop1_ph: begin
        imm_next = {{21{w[9]}}, w[9:0], 1'b0}; // RULE14
        aux_next = {27'h0, w[19:16], 1'b0}; // RULE14
      end
      op_ldi_lo, op_ldi_hi, op_ldi_z: begin
        imm_next = {16'h0, w[15:0]}; // RULE16
      end
      op_ldi_x: imm_next = {{16{w[15]}}, w[15:0]}; // RULE16
      op_jump_l, op_call: begin
        imm_next = {{7{w[23]}}, w[23:0], 1'b0}; // RULE17
      end
      op_ld_d, op_ld_p, op_st_d, op_st_p: begin
        imm_next = {15'h0, w[14:0], 2'b00}; // RULE18 RULE21
      end
      op_ld_hz, op_ld_hx, op_st_h: begin
        imm_next = {16'h0, w[14:0], 1'b0}; // RULE19 RULE20 RULE21
      end
      op_ld_bz, op_ld_bx, op_st_b: begin
        imm_next = {17'h0, w[14:0]}; // RULE19 RULE20 RULE21
      end
      op_link: imm_next = {14'h0, w[15:0], 2'b00}; // RULE22
      default: begin
        imm_next = 32'h0;
        aux_next = 32'h0;
      end
    endcase
  end

  // mode flags beside the immediate
  always_comb begin
    half_op = op_next inside {op_half_asr, op_half_satl,
                              op_half_lsl, op_half_lsr};
    sub_next = (op_next inside {[op_ld_d:op_st_p]}) &&
               fetch_word_in[`WOD_SUB_BIT]; // RULE18 RULE19 RULE20 RULE21
    sat_next = op_next inside {op_half_satl, op_vec_satl,
                               op_word_satl}; // RULE3 RULE5 RULE7
    unit_one_next = op_next inside {op_acc1_asr, op_acc1_lsl, op_acc1_lsr,
                                    op_acc1_rotate, op_loop1, op_loop1_p,
                                    op_loop1_ph}; // RULE10 RULE14 RULE15
    halved_next = op_next inside {op_loop0_ph, op_loop1_ph}; // RULE15
  end

  // ============================================================
  // output stage: holds until the execution units accept it
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dec_valid_out <= 1'b0;
    end else if (fire) begin
      dec_valid_out <= 1'b1;
    end else if (exec_ready_in) begin
      dec_valid_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dec_claim_out <= 1'b0;
      dec_illegal_out <= 1'b0;
      dec_op_out <= op_none;
      dec_word_out <= 32'h0;
    end else if (fire) begin
      dec_claim_out <= in_scope;
      // unmatched words in scope still go out valid, as op_none with dec_illegal_out set
      dec_illegal_out <= in_scope && (op_next == op_none); // RULE23
      dec_op_out <= op_next;
      dec_word_out <= fetch_word_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dec_imm_out <= 32'h0;
      dec_aux_out <= 32'h0;
      dec_sub_out <= 1'b0;
      dec_src_high_out <= 1'b0;
      dec_dst_high_out <= 1'b0;
      dec_sat_out <= 1'b0;
      dec_unit_one_out <= 1'b0;
      dec_count_halved_out <= 1'b0;
    end else if (fire) begin
      dec_imm_out <= imm_next;
      dec_aux_out <= aux_next;
      dec_sub_out <= sub_next;
      dec_src_high_out <= half_op &&
                          fetch_word_in[`WOD_SRC_HALF_BIT]; // RULE2 RULE3
      dec_dst_high_out <= half_op &&
                          fetch_word_in[`WOD_DST_HALF_BIT]; // RULE2 RULE4
      dec_sat_out <= sat_next;
      dec_unit_one_out <= unit_one_next;
      dec_count_halved_out <= halved_next;
    end
  end

  // ============================================================
  // checks
  a_align_shift: assert property ( // RULE1
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && mif.hit[op_align3] |=>
      dec_op_out == op_align3 && dec_imm_out == 32'h3)
    else $error("align three did not give three bytes");

  a_half_asr_imm: assert property ( // RULE2
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && mif.hit[op_half_asr] |=>
      dec_op_out == op_half_asr && !dec_sat_out &&
      dec_imm_out == {28'h0, $past(fetch_word_in[6:3])} &&
      dec_dst_high_out == $past(fetch_word_in[13]))
    else $error("half arithmetic shift decoded wrongly");

  a_half_sat_flag: assert property ( // RULE3
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && mif.hit[op_half_satl] |=>
      dec_sat_out && dec_src_high_out == $past(fetch_word_in[12]))
    else $error("half saturating shift lost its flag");

  a_half_lsr_split: assert property ( // RULE4
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && fetch_word_in[31:16] == 16'hc680 &&
      fetch_word_in[15:14] == 2'b10 && fetch_word_in[8:7] == 2'b11 |=>
      dec_op_out == op_half_lsr)
    else $error("offset 0x180 sub-range not a right shift");

  a_vec_asr_imm: assert property ( // RULE5
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && mif.hit[op_vec_asr] |=>
      dec_imm_out == {27'h0, $past(fetch_word_in[7:3])})
    else $error("paired-half shift amount wrong");

  a_word_rotate: assert property ( // RULE9
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && mif.hit[op_word_rotate] && fetch_word_in[8] |=>
      dec_imm_out[31:6] == 26'h3ff_ffff)
    else $error("rotate amount not sign extended");

  a_acc_unit: assert property ( // RULE10
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && (mif.hit[op_acc0_asr] || mif.hit[op_acc1_asr]) |=>
      dec_unit_one_out == (dec_op_out == op_acc1_asr))
    else $error("accumulator selection wrong");

  a_noop_single: assert property ( // RULE13
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && fetch_word_in == 32'hc803_1801 |=>
      dec_op_out != op_multi_noop && dec_illegal_out)
    else $error("no-op must match one word only");

  a_loop_halved: assert property ( // RULE15
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && mif.hit[op_loop1_ph] |=>
      dec_count_halved_out && dec_unit_one_out)
    else $error("halved loop count not flagged");

  a_jump_offset: assert property ( // RULE17
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && mif.hit[op_call] |=>
      dec_imm_out[0] == 1'b0 &&
      dec_imm_out[24:1] == $past(fetch_word_in[23:0]))
    else $error("call offset wrong");

  a_load_subtract: assert property ( // RULE18
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && mif.hit[op_ld_d] |=>
      dec_sub_out == $past(fetch_word_in[15]) && dec_imm_out[1:0] == 2'b00)
    else $error("word load offset sign or scale wrong");

  a_frame_link: assert property ( // RULE22
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && mif.hit[op_link] |=>
      dec_imm_out == {14'h0, $past(fetch_word_in[15:0]), 2'b00})
    else $error("frame size wrong");

  a_illegal_flag: assert property ( // RULE23
    @(posedge clk_in) disable iff (!reset_n_in)
    fire && in_scope && mif.hit == '0 |=>
      dec_illegal_out && dec_claim_out && dec_op_out == op_none)
    else $error("unmatched word not flagged illegal");

  a_output_hold: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    dec_valid_out && !exec_ready_in |=>
      dec_valid_out && $stable(dec_word_out) && $stable(dec_op_out))
    else $error("output changed while stalled");
endmodule : wod_decoder

// File: verif/wod_fetch_model.sv
// partner model: fetch stage offering words, execution side taking them
// assumes send is entered just after a rising clk_in edge
`timescale 1ns/1ps

module wod_fetch_model (
  input wire logic clk_in,
  input wire logic fetch_ready_in,
  input wire logic stall_in,
  output logic fetch_valid_out,
  output logic [31:0] fetch_word_out,
  output logic exec_ready_out
);
  // ============================================================
  // execution side: accepts unless the bench stalls it
  assign exec_ready_out = !stall_in;

  initial begin
    fetch_valid_out = 1'b0;
    fetch_word_out = 32'h5a5a_a5a5;
  end

  // ============================================================
  // fetch side: word held until taken; keep leaves valid up
  task automatic send(input logic [31:0] w, input bit keep);
    fetch_valid_out = 1'b1;
    fetch_word_out = w;
    // ready only moves after rising edges, so negedge sees it settled
    @(negedge clk_in);
    while (!fetch_ready_in) @(negedge clk_in);
    @(posedge clk_in);
    #1;
    if (!keep) begin
      fetch_valid_out = 1'b0;
      // idle bus shows no stale word
      fetch_word_out = ~w;
    end
  endtask : send
endmodule : wod_fetch_model

// File: verif/wod_decoder_test.sv
// self-checking bench for the wide opcode decoder
// assumes the fetch model partner; expectations built from the code map
`timescale 1ns/1ps

module wod_decoder_test;
  import wod_pkg::*;
  logic clk_in, reset_n_in, stall;
  logic f_valid, f_ready, e_ready;
  logic [31:0] f_word, d_word, d_imm, d_aux;
  logic d_valid, d_claim, d_ill, d_sub, d_src, d_dst, d_sat, d_one, d_half;
  wod_op_t d_op;
  int mismatches, cmp_count;

  always #2 clk_in = ~clk_in;

  wod_decoder wod_decoder_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .fetch_valid_in(f_valid), .fetch_word_in(f_word),
    .fetch_ready_out(f_ready), .exec_ready_in(e_ready),
    .dec_valid_out(d_valid), .dec_claim_out(d_claim),
    .dec_illegal_out(d_ill), .dec_op_out(d_op), .dec_word_out(d_word),
    .dec_imm_out(d_imm), .dec_aux_out(d_aux), .dec_sub_out(d_sub),
    .dec_src_high_out(d_src), .dec_dst_high_out(d_dst),
    .dec_sat_out(d_sat), .dec_unit_one_out(d_one),
    .dec_count_halved_out(d_half));

  wod_fetch_model wod_fetch_model_i (.clk_in(clk_in),
    .fetch_ready_in(f_ready), .stall_in(stall), .fetch_valid_out(f_valid),
    .fetch_word_out(f_word), .exec_ready_out(e_ready));

  // ============================================================
  // compare tasks
  task automatic cmp_vec(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_vec

  task automatic cmp_op(input wod_op_t got, exp, input logic [31:0] w);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t class of %h exp %s", $time, w, exp.name());
    end
  endtask : cmp_op

  function automatic bit in_scope(input logic [31:0] w);
    return w[31:16] == 16'hc60d || w[31:16] == 16'hc803 ||
      (w[31:16] >= 16'hc680 && w[31:16] <= 16'hc683) ||
      (w[31:24] >= 8'he0 && w[31:24] <= 8'he8);
  endfunction : in_scope

  task automatic chk_idle;
    cmp_vec(32'({d_valid, d_claim, d_ill, f_ready}), 32'h1, "idle");
    cmp_op(d_op, op_none, 32'h0);
  endtask : chk_idle

  // ============================================================
  // class map, sent back to back
  localparam int NT = 54;
  localparam logic [37:0] TBL [NT] = '{
    {op_align1, 32'hc60d_0000}, {op_align2, 32'hc60d_4e3f},
    {op_align3, 32'hc60d_8e3f}, {op_half_asr, 32'hc680_0180},
    {op_half_asr, 32'hc680_3fff}, {op_half_satl, 32'hc680_7e7f},
    {op_half_lsl, 32'hc680_8000}, {op_half_lsr, 32'hc680_8180},
    {op_vec_asr, 32'hc681_0100}, {op_vec_satl, 32'hc681_4eff},
    {op_vec_lsl, 32'hc681_8000}, {op_vec_lsr, 32'hc681_8fff},
    {op_word_asr, 32'hc682_0100}, {op_word_satl, 32'hc682_4000},
    {op_word_lsl, 32'hc682_8000}, {op_word_lsr, 32'hc682_8100},
    {op_word_rotate, 32'hc682_cfff}, {op_acc0_asr, 32'hc683_0100},
    {op_acc1_asr, 32'hc683_11f8}, {op_acc0_lsl, 32'hc683_4000},
    {op_acc0_lsr, 32'hc683_4100}, {op_acc1_lsl, 32'hc683_5000},
    {op_acc1_lsr, 32'hc683_51f8}, {op_acc0_rotate, 32'hc683_8000},
    {op_acc1_rotate, 32'hc683_91f8}, {op_multi_noop, 32'hc803_1800},
    {op_loop0, 32'he08f_03ff}, {op_loop1, 32'he090_0000},
    {op_loop0_p, 32'he0a0_0000}, {op_loop1_ph, 32'he0ff_f3ff},
    {op_ldi_lo, 32'he100_0000}, {op_ldi_hi, 32'he140_0000},
    {op_jump_l, 32'he200_0000}, {op_call, 32'he3ff_ffff},
    {op_ld_p, 32'he500_0000}, {op_ld_bz, 32'he480_0000},
    {op_ld_hx, 32'he540_0000}, {op_ld_bx, 32'he5bf_ffff},
    {op_st_d, 32'he600_0000}, {op_st_h, 32'he640_0000},
    {op_link, 32'he800_ffff}, {op_frame_pop, 32'he801_0000},
    {op_loop1_p, 32'he0bf_f3ff}, {op_loop0_ph, 32'he0e0_0000},
    {op_ldi_x, 32'he13f_ffff}, {op_ldi_z, 32'he19f_ffff},
    {op_ld_d, 32'he43f_ffff}, {op_ld_hz, 32'he47f_ffff},
    {op_st_b, 32'he6bf_ffff}, {op_st_p, 32'he700_8000},
    {op_none, 32'hc803_1801}, {op_none, 32'he4c0_0000},
    {op_none, 32'hc683_0101}, {op_none, 32'he801_0001}
  };

  task automatic chk_class(input logic [31:0] w, input wod_op_t op,
                           input bit keep);
    wod_fetch_model_i.send(w, keep);
    cmp_vec(32'(d_valid), 32'h1, "valid");
    cmp_op(d_op, op, w);
    cmp_vec(32'({d_claim, d_ill}),
      32'({in_scope(w), in_scope(w) && op == op_none}), "claim");
    cmp_vec(d_word, w, "word");
  endtask : chk_class

  task automatic run_table;
    @(posedge clk_in);
    #1;
    for (int i = 0; i < NT; i++) begin
      chk_class(TBL[i][31:0], wod_op_t'(TBL[i][37:32]), i != NT - 1);
    end
    @(posedge clk_in);
    #1;
    chk_class(32'hc60c_4000, op_none, 1'b0);
    @(posedge clk_in);
    #1;
    chk_class(32'hc680_0000, op_none, 1'b0);
  endtask : run_table

  // ============================================================
  // immediates and flags: {sub, src, dst, sat, one, halved}
  task automatic chk_field(input logic [31:0] w, imm, aux,
                           input logic [5:0] fl, care);
    @(posedge clk_in);
    #1;
    wod_fetch_model_i.send(w, 1'b0);
    cmp_vec(d_imm, imm, "imm");
    cmp_vec(d_aux, aux, "aux");
    cmp_vec(32'({d_sub, d_src, d_dst, d_sat, d_one, d_half} & care),
      32'(fl), "flags");
  endtask : chk_field

  task automatic run_fields;
    chk_field(32'hc60d_8000, 32'h3, 32'h0, 6'h00, 6'h00);
    chk_field(32'hc680_3188, 32'h1, 32'h0, 6'h18, 6'h3f);
    chk_field(32'hc680_6078, 32'hf, 32'h0, 6'h0c, 6'h3f);
    chk_field(32'hc681_01f8, 32'h1f, 32'h0, 6'h00, 6'h3f);
    chk_field(32'hc682_c1f8, 32'hffff_ffff, 32'h0, 6'h0, 6'h0);
    chk_field(32'hc683_5108, 32'h1, 32'h0, 6'h02, 6'h02);
    chk_field(32'he08a_0201, 32'hffff_fc02, 32'h14, 6'h0, 6'h3);
    chk_field(32'he0f3_0004, 32'h8, 32'h6, 6'h03, 6'h03);
    chk_field(32'he120_8000, 32'hffff_8000, 32'h0, 6'h0, 6'h0);
    chk_field(32'he180_8000, 32'h8000, 32'h0, 6'h0, 6'h0);
    chk_field(32'he2ff_ffff, 32'hffff_fffe, 32'h0, 6'h0, 6'h0);
    chk_field(32'he400_8005, 32'h14, 32'h0, 6'h20, 6'h20);
    chk_field(32'he440_8003, 32'h6, 32'h0, 6'h20, 6'h20);
    chk_field(32'he580_7fff, 32'h7fff, 32'h0, 6'h00, 6'h20);
    chk_field(32'he700_0002, 32'h8, 32'h0, 6'h00, 6'h20);
    chk_field(32'he800_0010, 32'h40, 32'h0, 6'h0, 6'h0);
  endtask : run_fields

  // ============================================================
  // execution stall: result stands, next word refused until ready
  task automatic stall_hold;
    @(posedge clk_in);
    #1;
    stall = 1'b1;
    wod_fetch_model_i.send(32'he801_0000, 1'b1);
    fork
      wod_fetch_model_i.send(32'hc803_1800, 1'b0);
    join_none
    repeat (3) begin
      @(posedge clk_in);
      #1;
      cmp_vec(32'({d_valid, f_ready}), 32'h2, "stall ready");
      cmp_op(d_op, op_frame_pop, 32'he801_0000);
    end
    stall = 1'b0;
    wait fork;
    cmp_op(d_op, op_multi_noop, 32'hc803_1800);
    @(posedge clk_in);
    #1;
    cmp_vec(32'(d_valid), 32'h0, "drained");
  endtask : stall_hold

  // reset in mid-run clears a standing result
  task automatic mid_reset;
    @(posedge clk_in);
    #1;
    stall = 1'b1;
    wod_fetch_model_i.send(32'he200_0000, 1'b0);
    cmp_vec(32'(d_valid), 32'h1, "standing");
    reset_n_in = 1'b0;
    #1;
    chk_idle();
    @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    stall = 1'b0;
  endtask : mid_reset

  // ============================================================
  // verdict
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clk_in = 1'b0;
    reset_n_in = 1'b0;
    stall = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    chk_idle();
    run_table();
    run_fields();
    stall_hold();
    mid_reset();
    run_table();
    report_and_stop();
  end

  // under two hundred cycles expected; far beyond that means a hang
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
endmodule : wod_decoder_test
